// ==== drv_desc_pkg.sv ====
// constants, types and command matcher for the driver strength descriptor
package drv_desc_pkg;
   // ----------------------------------------------------------------
   // descriptor field positions
   // ----------------------------------------------------------------
   localparam int DESC_W         = 32;
   localparam int CNT_HI         = 31;
   localparam int CNT_LO         = 30;
   localparam int RSVD_BIT       = 29;
   localparam int ACCESS_BIT     = 28;
   localparam int PLACE_BIT      = 27;
   localparam int POS_HI         = 26;
   localparam int POS_LO         = 24;
   localparam int LADDR_HI       = 23;
   localparam int LADDR_LO       = 16;
   localparam int FLAG_8D_BIT    = 23;
   localparam int FLAG_8S_BIT    = 22;
   localparam int FLAG_4D_BIT    = 21;
   localparam int FLAG_4S_BIT    = 20;
   localparam int DUMMY_HI       = 19;
   localparam int DUMMY_LO       = 16;
   localparam int RD_OP_HI       = 15;
   localparam int RD_OP_LO       = 8;
   localparam int WR_OP_HI       = 7;
   localparam int WR_OP_LO       = 0;
   // ----------------------------------------------------------------
   // values and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  OP_NONE      = 8'h00;
   localparam logic [1:0]  CNT_NONE     = 2'h0;
   localparam logic [3:0]  DUMMY_NONE   = 4'h0;
   localparam logic [31:0] DESC_RST     = 32'h0000_0000;
   localparam logic [2:0]  STRENGTH_RST = 3'h0;
   localparam logic [7:0]  RDATA_RST    = 8'h00;
   localparam int          STRENGTH_W   = 3;
   // address width of the command address space
   localparam logic [1:0]  AW_8         = 2'h0;
   localparam logic [1:0]  AW_24        = 2'h1;
   localparam logic [1:0]  AW_32        = 2'h2;
   // ----------------------------------------------------------------
   // lane modes of an incoming command
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      LANE_1S1S1S,
      LANE_4S4S4S,
      LANE_4S4D4D,
      LANE_8S8S8S,
      LANE_8D8D8D,
      LANE_OTHER
   } lane_mode_t;
endpackage : drv_desc_pkg

`timescale 1ns/10ps
module desc_cmd_match
(
   // published descriptor
   input  wire logic [31:0] desc,
   // incoming command
   input  wire logic [7:0]  cmd_opcode,
   input  wire logic [31:0] cmd_addr,
   input  wire logic [2:0]  cmd_lane_mode,
   input  wire logic [3:0]  cmd_dummy,
   // match results
   output logic             hit_rd,
   output logic             hit_wr
);
   logic       addr_ok;
   logic       dummy_ok;
   logic       ctl_ok;
   logic [7:0] addr_byte;
   logic [3:0] dsc_dummy;

   // ----------------------------------------------------------------
   // address and dummy checks
   // ----------------------------------------------------------------
   always_comb
   begin
      addr_byte = desc[drv_desc_pkg::PLACE_BIT] ? cmd_addr[15:8] : cmd_addr[7:0];
      addr_ok   = !desc[drv_desc_pkg::ACCESS_BIT] ||
                  (addr_byte == desc[drv_desc_pkg::LADDR_HI:drv_desc_pkg::LADDR_LO]);
      dsc_dummy = desc[drv_desc_pkg::DUMMY_HI:drv_desc_pkg::DUMMY_LO];
      dummy_ok  = 1'b1;
      if (!desc[drv_desc_pkg::ACCESS_BIT])
      begin
         unique case (drv_desc_pkg::lane_mode_t'(cmd_lane_mode))
            drv_desc_pkg::LANE_1S1S1S:
               dummy_ok = (cmd_dummy == drv_desc_pkg::DUMMY_NONE);
            drv_desc_pkg::LANE_4S4S4S:
               dummy_ok = !desc[drv_desc_pkg::FLAG_4S_BIT] || (cmd_dummy == dsc_dummy);
            drv_desc_pkg::LANE_4S4D4D:
               dummy_ok = !desc[drv_desc_pkg::FLAG_4D_BIT] || (cmd_dummy == dsc_dummy);
            drv_desc_pkg::LANE_8S8S8S:
               dummy_ok = !desc[drv_desc_pkg::FLAG_8S_BIT] || (cmd_dummy == dsc_dummy);
            drv_desc_pkg::LANE_8D8D8D:
               dummy_ok = !desc[drv_desc_pkg::FLAG_8D_BIT] || (cmd_dummy == dsc_dummy);
            default:
               dummy_ok = 1'b1; // LANE_OTHER and unlisted mode codes stay accepted
         endcase
      end
      ctl_ok = (desc[drv_desc_pkg::CNT_HI:drv_desc_pkg::CNT_LO] != drv_desc_pkg::CNT_NONE);
      hit_rd = ctl_ok && addr_ok && dummy_ok &&
               (desc[drv_desc_pkg::RD_OP_HI:drv_desc_pkg::RD_OP_LO] != drv_desc_pkg::OP_NONE) &&
               (cmd_opcode == desc[drv_desc_pkg::RD_OP_HI:drv_desc_pkg::RD_OP_LO]);
      hit_wr = ctl_ok && addr_ok && dummy_ok &&
               (desc[drv_desc_pkg::WR_OP_HI:drv_desc_pkg::WR_OP_LO] != drv_desc_pkg::OP_NONE) &&
               (cmd_opcode == desc[drv_desc_pkg::WR_OP_HI:drv_desc_pkg::WR_OP_LO]);
   end
endmodule : desc_cmd_match

// ==== drv_strength_desc.sv ====
// driver strength descriptor word and volatile strength control bits
`timescale 1ns/10ps
module drv_strength_desc
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // descriptor configuration
   input  wire logic        cfg_load,
   input  wire logic [1:0]  cfg_bit_count,
   input  wire logic        cfg_addressed,
   input  wire logic        cfg_addr_byte1,
   input  wire logic [1:0]  cfg_addr_width,
   input  wire logic [2:0]  cfg_lsb_pos,
   input  wire logic [7:0]  cfg_local_addr,
   input  wire logic [3:0]  cfg_mode_flags,
   input  wire logic [3:0]  cfg_dummy,
   input  wire logic [7:0]  cfg_rd_opcode,
   input  wire logic [7:0]  cfg_wr_opcode,
   output logic             cfg_error,
   // descriptor read port
   input  wire logic        desc_rd_req,
   output logic             desc_rd_ack,
   output logic [31:0]      desc_rd_data,
   // strength command port
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_opcode,
   input  wire logic [31:0] cmd_addr,
   input  wire logic [2:0]  cmd_lane_mode,
   input  wire logic [3:0]  cmd_dummy,
   input  wire logic [7:0]  cmd_wdata,
   output logic             cmd_ack,
   output logic             cmd_hit_rd,
   output logic             cmd_hit_wr,
   output logic [7:0]       cmd_rdata,
   // strength control bits
   output logic [2:0]       strength
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [31:0] desc;
      logic        cfg_err;
      logic        rd_ack;
      logic [31:0] rd_data;
      logic        ack;
      logic        hit_rd;
      logic        hit_wr;
      logic [7:0]  rdata;
      logic [2:0]  strength;
   } state_t;

   state_t state_q;
   state_t state_d;
   logic   match_rd;
   logic   match_wr;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // mask of the live control bits for a bit count
   function automatic logic [2:0] cnt_mask(input logic [1:0] cnt);
      logic [2:0] m;
      m = 3'h0;
      unique case (cnt)
         2'h0: m = 3'h0;
         2'h1: m = 3'h1;
         2'h2: m = 3'h3;
         2'h3: m = 3'h7;
      endcase
      return m;
   endfunction : cnt_mask

   // true when byte 1 placement meets 8-bit addressing
   function automatic logic bad_place(input logic byte1, input logic [1:0] aw);
      return byte1 && (aw == drv_desc_pkg::AW_8);
   endfunction : bad_place

   // true for an address width code that has no meaning
   function automatic logic bad_width(input logic [1:0] aw);
      return (aw != drv_desc_pkg::AW_8) && (aw != drv_desc_pkg::AW_24) &&
             (aw != drv_desc_pkg::AW_32);
   endfunction : bad_width

   // assemble the descriptor word from configuration
   function automatic logic [31:0] build_desc
   (
      input logic [1:0] cnt,
      input logic       addressed,
      input logic       byte1,
      input logic [1:0] aw,
      input logic [2:0] pos,
      input logic [7:0] laddr,
      input logic [3:0] flags,
      input logic [3:0] dummy,
      input logic [7:0] rd_op,
      input logic [7:0] wr_op
   );
      logic [31:0] w;
      w = drv_desc_pkg::DESC_RST;
      w[drv_desc_pkg::CNT_HI:drv_desc_pkg::CNT_LO] = cnt;
      w[drv_desc_pkg::RSVD_BIT] = 1'b0;
      w[drv_desc_pkg::ACCESS_BIT] = addressed;
      w[drv_desc_pkg::PLACE_BIT] = byte1 && !bad_place(byte1, aw);
      w[drv_desc_pkg::POS_HI:drv_desc_pkg::POS_LO] = pos;
      if (addressed)
      begin
         w[drv_desc_pkg::LADDR_HI:drv_desc_pkg::LADDR_LO] = laddr;
      end
      else
      begin
         w[drv_desc_pkg::FLAG_8D_BIT] = flags[3];
         w[drv_desc_pkg::FLAG_8S_BIT] = flags[2];
         w[drv_desc_pkg::FLAG_4D_BIT] = flags[1];
         w[drv_desc_pkg::FLAG_4S_BIT] = flags[0];
         w[drv_desc_pkg::DUMMY_HI:drv_desc_pkg::DUMMY_LO] = dummy;
      end
      w[drv_desc_pkg::RD_OP_HI:drv_desc_pkg::RD_OP_LO] = rd_op;
      w[drv_desc_pkg::WR_OP_HI:drv_desc_pkg::WR_OP_LO] = wr_op;
      return w;
   endfunction : build_desc

   // control bit count field of a descriptor
   function automatic logic [1:0] desc_count(input logic [31:0] w);
      return w[drv_desc_pkg::CNT_HI:drv_desc_pkg::CNT_LO];
   endfunction : desc_count

   // least control bit position field of a descriptor
   function automatic logic [2:0] desc_pos(input logic [31:0] w);
      return w[drv_desc_pkg::POS_HI:drv_desc_pkg::POS_LO];
   endfunction : desc_pos

   // live control bits placed at their position in the register byte
   function automatic logic [7:0] strength_out
   (
      input logic [2:0] value,
      input logic [2:0] mask,
      input logic [2:0] pos
   );
      logic [7:0] b;
      b = {5'h00, value & mask};
      b = b << pos;
      return b;
   endfunction : strength_out

   // live control bits taken from their position in a written byte
   function automatic logic [2:0] strength_in
   (
      input logic [7:0] wbyte,
      input logic [2:0] mask,
      input logic [2:0] pos
   );
      logic [7:0] b;
      b = wbyte >> pos;
      return b[2:0] & mask;
   endfunction : strength_in

   // true when a configuration cannot be published as asked
   function automatic logic cfg_fault(input logic byte1, input logic [1:0] aw);
      return bad_place(byte1, aw) || bad_width(aw);
   endfunction : cfg_fault

   // ----------------------------------------------------------------
   // command matching
   // ----------------------------------------------------------------
   desc_cmd_match i_desc_cmd_match
   (
      .desc          (state_q.desc),
      .cmd_opcode    (cmd_opcode),
      .cmd_addr      (cmd_addr),
      .cmd_lane_mode (cmd_lane_mode),
      .cmd_dummy     (cmd_dummy),
      .hit_rd        (match_rd),
      .hit_wr        (match_wr)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [2:0]  mask;
      logic [2:0]  pos;
      mask    = cnt_mask(desc_count(state_q.desc));
      pos     = desc_pos(state_q.desc);
      state_d = state_q;
      // configuration capture
      if (cfg_load)
      begin
         state_d.desc    = build_desc(cfg_bit_count, cfg_addressed, cfg_addr_byte1,
                                      cfg_addr_width, cfg_lsb_pos, cfg_local_addr,
                                      cfg_mode_flags, cfg_dummy, cfg_rd_opcode,
                                      cfg_wr_opcode);
         state_d.cfg_err = cfg_fault(cfg_addr_byte1, cfg_addr_width);
      end
      // descriptor read answer
      state_d.rd_ack  = desc_rd_req;
      if (desc_rd_req)
      begin
         state_d.rd_data = state_q.desc;
      end
      // strength command answer
      state_d.ack    = cmd_valid;
      state_d.hit_rd = cmd_valid && match_rd;
      state_d.hit_wr = cmd_valid && match_wr;
      if (cmd_valid && match_rd)
      begin
         state_d.rdata = strength_out(state_q.strength, mask, pos);
      end
      if (cmd_valid && match_wr)
      begin
         state_d.strength = strength_in(cmd_wdata, mask, pos);
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state_q.desc     <= drv_desc_pkg::DESC_RST;
         state_q.cfg_err  <= 1'b0;
         state_q.rd_ack   <= 1'b0;
         state_q.rd_data  <= drv_desc_pkg::DESC_RST;
         state_q.ack      <= 1'b0;
         state_q.hit_rd   <= 1'b0;
         state_q.hit_wr   <= 1'b0;
         state_q.rdata    <= drv_desc_pkg::RDATA_RST;
         state_q.strength <= drv_desc_pkg::STRENGTH_RST;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cfg_error    = state_q.cfg_err;
   assign desc_rd_ack  = state_q.rd_ack;
   assign desc_rd_data = state_q.rd_data;
   assign cmd_ack      = state_q.ack;
   assign cmd_hit_rd   = state_q.hit_rd;
   assign cmd_hit_wr   = state_q.hit_wr;
   assign cmd_rdata    = state_q.rdata;
   assign strength     = state_q.strength;
endmodule : drv_strength_desc

// ==== drv_strength_desc_props.sv ====
// concurrent checks on the descriptor ports of the driver strength block
`timescale 1ns/10ps
module drv_strength_desc_props
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // descriptor configuration
   input wire logic        cfg_load,
   input wire logic [1:0]  cfg_bit_count,
   input wire logic        cfg_addressed,
   input wire logic        cfg_addr_byte1,
   input wire logic [1:0]  cfg_addr_width,
   input wire logic [2:0]  cfg_lsb_pos,
   input wire logic [7:0]  cfg_local_addr,
   input wire logic [3:0]  cfg_mode_flags,
   input wire logic [3:0]  cfg_dummy,
   input wire logic [7:0]  cfg_rd_opcode,
   input wire logic [7:0]  cfg_wr_opcode,
   // descriptor read port
   input wire logic        desc_rd_req,
   input wire logic        desc_rd_ack,
   input wire logic [31:0] desc_rd_data
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // load followed at once by a read
   // ----------------------------------------------------------------
   sequence s_load_read;
      cfg_load ##1 (desc_rd_req && !cfg_load) ##1 desc_rd_ack;
   endsequence
   property p_count;
      s_load_read |-> desc_rd_data[31:30] == $past(cfg_bit_count, 2);
   endproperty
   a_count: assert property (p_count) else $error("bit count field wrong");
   property p_rsvd;
      desc_rd_ack |-> !desc_rd_data[29];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_access;
      s_load_read |-> desc_rd_data[28] == $past(cfg_addressed, 2);
   endproperty
   a_access: assert property (p_access) else $error("access bit wrong");
   property p_place;
      s_load_read |-> desc_rd_data[27] == ($past(cfg_addr_byte1, 2)
         && $past(cfg_addr_width, 2) != drv_desc_pkg::AW_8);
   endproperty
   a_place: assert property (p_place) else $error("placement bit wrong");
   property p_pos;
      s_load_read |-> desc_rd_data[26:24] == $past(cfg_lsb_pos, 2);
   endproperty
   a_pos: assert property (p_pos) else $error("bit position wrong");
   property p_field;
      s_load_read |-> desc_rd_data[23:16] == ($past(cfg_addressed, 2) ?
         $past(cfg_local_addr, 2) : {$past(cfg_mode_flags, 2), $past(cfg_dummy, 2)});
   endproperty
   a_field: assert property (p_field) else $error("address or mode field wrong");
   property p_ops;
      s_load_read |-> desc_rd_data[15:0] == {$past(cfg_rd_opcode, 2), $past(cfg_wr_opcode, 2)};
   endproperty
   a_ops: assert property (p_ops) else $error("opcode fields wrong");
   property p_ack;
      desc_rd_req |=> desc_rd_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("read not answered");
endmodule : drv_strength_desc_props

bind drv_strength_desc drv_strength_desc_props i_props (.*);

// ==== strength_host.sv ====
// host model issuing descriptor reads and strength commands
`timescale 1ns/10ps
module strength_host
(
   // clock
   input wire logic        clk_sys,
   // descriptor read
   output logic            desc_rd_req,
   input wire logic        desc_rd_ack,
   input wire logic [31:0] desc_rd_data,
   // strength command
   output logic            cmd_valid,
   output logic [7:0]      cmd_opcode,
   output logic [31:0]     cmd_addr,
   output logic [2:0]      cmd_lane_mode,
   output logic [3:0]      cmd_dummy,
   output logic [7:0]      cmd_wdata,
   input wire logic        cmd_ack,
   input wire logic        cmd_hit_rd,
   input wire logic        cmd_hit_wr,
   input wire logic [7:0]  cmd_rdata
);
   initial {desc_rd_req, cmd_valid, cmd_opcode, cmd_addr, cmd_lane_mode, cmd_dummy, cmd_wdata} = '0;
   // called just after an edge
   task read_desc(output logic [31:0] d, output logic a);
      desc_rd_req <= 1'b1;
      @(posedge clk_sys);
      desc_rd_req <= 1'b0;
      #1 d = desc_rd_data;
      a = desc_rd_ack;
   endtask : read_desc
   // opcode and address from decoded fields any mode or dummy tried
   task send(input logic [7:0] op, input logic [31:0] ad, input logic [2:0] ln,
             input logic [3:0] dm, input logic [7:0] wd, output logic [10:0] r);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      {cmd_opcode, cmd_addr, cmd_lane_mode, cmd_dummy, cmd_wdata} <= {op, ad, ln, dm, wd};
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      cmd_addr <= ~ad;
      cmd_wdata <= ~wd;
      #1 r = {cmd_ack, cmd_hit_rd, cmd_hit_wr, cmd_rdata};
   endtask : send
endmodule : strength_host

// ==== tb_drv_strength_desc.sv ====
// testbench for the driver strength descriptor block
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
   $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb_drv_strength_desc;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, cfg_load = 1'b0;
   logic        cfg_addressed = 1'b0, cfg_addr_byte1 = 1'b0, cfg_error, desc_rd_req, desc_rd_ack;
   logic        cmd_valid, cmd_ack, cmd_hit_rd, cmd_hit_wr;
   logic [1:0]  cfg_bit_count = '0, cfg_addr_width = '0;
   logic [2:0]  cfg_lsb_pos = '0, cmd_lane_mode, strength;
   logic [3:0]  cfg_mode_flags = '0, cfg_dummy = '0, cmd_dummy;
   logic [7:0]  cfg_local_addr = '0, cfg_rd_opcode = '0, cfg_wr_opcode = '0;
   logic [7:0]  cmd_opcode, cmd_wdata, cmd_rdata;
   logic [31:0] desc_rd_data, cmd_addr;
   logic [10:0] r;
   int          num_errors = 0, checked = 0;
   drv_strength_desc i_drv_strength_desc (.*);
   strength_host i_strength_host (.*);
   always #5 clk_sys = ~clk_sys;
   task tally_and_finish;
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   task load(input logic [1:0] n, input logic ad, b1, input logic [1:0] aw, input logic [2:0] ps,
             input logic [7:0] la, input logic [3:0] fl, dm, input logic [7:0] ro, wo);
      @(posedge clk_sys);
      cfg_load <= 1'b1;
      {cfg_bit_count, cfg_addressed, cfg_addr_byte1, cfg_addr_width, cfg_lsb_pos} <= {n, ad, b1, aw, ps};
      {cfg_local_addr, cfg_mode_flags, cfg_dummy, cfg_rd_opcode, cfg_wr_opcode} <= {la, fl, dm, ro, wo};
      @(posedge clk_sys);
      cfg_load <= 1'b0;
   endtask : load
   task chk_desc(input logic [31:0] e);
      logic [31:0] d;
      logic        a;
      i_strength_host.read_desc(d, a);
      `CHK({a, d}, {1'b1, e})
   endtask : chk_desc
   task t_fields;
      @(posedge clk_sys);
      chk_desc(32'h0000_0000);
      for (int i = 0; i < 4; i++)
      begin
         load(i[1:0], 0, 0, 2'h2, 3'h2, 8'hFF, 4'(1 << i), 4'(15 - i), 8'h85, 8'h81);
         chk_desc({i[1:0], 3'b000, 3'h2, 4'(1 << i), 4'(15 - i), 16'h8581});
      end
      load(1, 1, 1, 2'h2, 3'h7, 8'h3C, 0, 0, 8'h65, 8'h61);
      chk_desc({5'b01011, 3'h7, 16'h3C65, 8'h61});
      `CHK(cfg_error, 1'b0)
      load(1, 1, 1, 2'h0, 3'h7, 8'h3C, 0, 0, 8'h65, 8'h61);
      chk_desc({5'b01010, 3'h7, 16'h3C65, 8'h61});
      `CHK(cfg_error, 1'b1)
      load(1, 1, 0, 2'h1, 3'h7, 8'h3C, 0, 0, 8'h65, 8'h61);
      chk_desc({5'b01010, 3'h7, 16'h3C65, 8'h61});
      `CHK(cfg_error, 1'b0)
      load(1, 1, 1, 2'h3, 3'h7, 8'h3C, 0, 0, 8'h65, 8'h61);
      chk_desc({5'b01011, 3'h7, 16'h3C65, 8'h61});
      `CHK(cfg_error, 1'b1)
   endtask : t_fields
   task t_direct;
      load(3, 0, 0, 2'h2, 3'h2, 8'h00, 4'h1, 4'h6, 8'h85, 8'h81);
      chk_desc({5'b11000, 3'h2, 8'h16, 16'h8581});
      i_strength_host.send(8'h81, 0, drv_desc_pkg::LANE_1S1S1S, 0, 8'h14, r);
      `CHK({r, strength}, {3'b101, 8'h00, 3'h5})
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_4S4S4S, 6, 0, r);
      `CHK(r, {3'b110, 8'h14})
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_1S1S1S, 3, 0, r);
      `CHK(r, {3'b100, 8'h14})
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_4S4S4S, 5, 0, r);
      `CHK(r, {3'b100, 8'h14})
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_8D8D8D, 9, 0, r);
      `CHK(r, {3'b110, 8'h14})
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_OTHER, 2, 0, r);
      `CHK(r, {3'b110, 8'h14})
      load(2, 0, 0, 2'h2, 3'h2, 8'h00, 4'hE, 4'h9, 8'h85, 8'h81);
      chk_desc({5'b10000, 3'h2, 8'hE9, 16'h8581});
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_4S4D4D, 9, 0, r);
      `CHK(r, {3'b110, 8'h04})
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_8S8S8S, 8, 0, r);
      `CHK(r, {3'b100, 8'h04})
      i_strength_host.send(8'h85, 0, drv_desc_pkg::LANE_4S4S4S, 3, 0, r);
      `CHK(r, {3'b110, 8'h04})
   endtask : t_direct
   task t_addressed;
      load(1, 1, 1, 2'h2, 3'h7, 8'h3C, 0, 0, 8'h65, 8'h61);
      chk_desc({5'b01011, 3'h7, 16'h3C65, 8'h61});
      i_strength_host.send(8'h61, 32'h0000_3C00, 0, 4'h9, 8'h80, r);
      `CHK({r, strength}, {3'b101, 8'h04, 3'h1})
      i_strength_host.send(8'h65, 32'h0000_3C00, 0, 0, 0, r);
      `CHK(r, {3'b110, 8'h80})
      i_strength_host.send(8'h65, 32'h0000_003C, 0, 0, 0, r);
      `CHK(r, {3'b100, 8'h80})
      load(1, 1, 1, 2'h2, 3'h7, 8'h3C, 0, 0, 8'h00, 8'h61);
      chk_desc({5'b01011, 3'h7, 16'h3C00, 8'h61});
      i_strength_host.send(8'h00, 32'h0000_3C00, 0, 0, 0, r);
      `CHK(r, {3'b100, 8'h80})
      load(0, 1, 1, 2'h2, 3'h7, 8'h3C, 0, 0, 8'h65, 8'h61);
      i_strength_host.send(8'h61, 32'h0000_3C00, 0, 0, 8'h00, r);
      `CHK({r, strength}, {3'b100, 8'h80, 3'h1})
   endtask : t_addressed
   initial
   begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_fields();
      t_direct();
      t_addressed();
      tally_and_finish();
   end
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      num_errors++;
      tally_and_finish();
   end
endmodule : tb_drv_strength_desc
